// ---- logic/eccte_top.sv ----
// Purpose: Exception type coding, exception return packets and cycle count packets.
// Assumes: Core events are on SYS_CLK_IN and are held until EVT_READY_OUT is high.
// Notes: The exception packet bytes are built elsewhere from EXC_TYPE_OUT and EXC_ADDR_OUT.
`timescale 1ns/1ps
`default_nettype none
module eccte_top #(
	parameter int TAG_W = 5,
	parameter int TAG_WRAP = 32,
	parameter int DEPTH_W = 6,
	parameter int MAX_DEPTH = 16,
	parameter int CNT_W = 12,
	parameter bit CC_IMPL = 1'b1
) (
	input wire logic SYS_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic PROFILE_MCU_IN,
	input wire logic EXC_VALID_IN,
	input wire logic [3:0] EXC_KIND_IN,
	input wire logic [8:0] EXC_NUM_IN,
	input wire logic EXC_ALIGN_IN,
	input wire logic [1:0] EXC_ISET_IN,
	input wire logic [31:0] EXC_ADDR_IN,
	output logic EXC_VALID_OUT,
	output logic [9:0] EXC_TYPE_OUT,
	output logic [31:0] EXC_ADDR_OUT,
	output logic EXC_ADDR_UNKNOWN_OUT,
	output logic EXC_REJECT_OUT,
	input wire logic ERET_IN,
	input wire logic COMMIT_IN,
	output logic EVT_READY_OUT,
	output logic [TAG_W-1:0] TAG_OUT,
	output logic [DEPTH_W-1:0] SPEC_DEPTH_OUT,
	output logic IMPLIED_COMMIT_OUT,
	input wire logic CC_ENABLE_IN,
	input wire logic CC_CONFIGURED_IN,
	input wire logic [CNT_W-1:0] CC_THRESHOLD_IN,
	output logic CC_EMIT_OUT,
	output logic [CNT_W-1:0] CC_COUNT_OUT,
	output logic [7:0] TRACE_DATA_OUT,
	output logic TRACE_VALID_OUT,
	input wire logic TRACE_READY_IN
);
	localparam int PB = eccte_pkg::PKT_BYTES;
	localparam int FW = eccte_pkg::CC_FIELD_W;

	// Returns the valid flag and the 10-bit type; reserved inputs come back invalid.
	function automatic logic [10:0] f_exc_code(input logic [3:0] kind, input logic [8:0] num);
		logic [10:0] r;
		r = 11'h000;
		case (kind)
			eccte_pkg::KIND_RESET: r = {1'b1, eccte_pkg::EXC_RESET};
			eccte_pkg::KIND_NMI: r = {1'b1, eccte_pkg::EXC_NMI};
			eccte_pkg::KIND_ESCALATED: r = {1'b1, eccte_pkg::EXC_ESCALATED};
			eccte_pkg::KIND_MEM_MGMT: r = {1'b1, eccte_pkg::EXC_MEM_MGMT};
			eccte_pkg::KIND_BUS_ERR: r = {1'b1, eccte_pkg::EXC_BUS_ERR};
			eccte_pkg::KIND_USAGE: r = {1'b1, eccte_pkg::EXC_USAGE};
			eccte_pkg::KIND_SUPV_CALL: r = {1'b1, eccte_pkg::EXC_SUPV_CALL};
			eccte_pkg::KIND_DBG_MON: r = {1'b1, eccte_pkg::EXC_DBG_MON};
			eccte_pkg::KIND_PEND_CALL: r = {1'b1, eccte_pkg::EXC_PEND_CALL};
			eccte_pkg::KIND_TICK: r = {1'b1, eccte_pkg::EXC_TICK};
			eccte_pkg::KIND_IRQ: begin
				if (num < eccte_pkg::IRQ_LOW_COUNT) begin
					r = {1'b1, eccte_pkg::EXC_IRQ_LOW + {1'b0, num}};
				end else if (num <= eccte_pkg::IRQ_LAST) begin
					r = {1'b1, eccte_pkg::EXC_IRQ_HIGH + {1'b0, num}};
				end
			end
			eccte_pkg::KIND_DBG_HALT: r = {1'b1, eccte_pkg::EXC_DBG_HALT};
			eccte_pkg::KIND_LAZY_FP: r = {1'b1, eccte_pkg::EXC_LAZY_FP};
			eccte_pkg::KIND_LOCKUP: r = {1'b1, eccte_pkg::EXC_LOCKUP};
			eccte_pkg::KIND_IMPDEF: begin
				if (num < eccte_pkg::IMPDEF_COUNT) begin
					r = {1'b1, eccte_pkg::EXC_IMPDEF + {1'b0, num}};
				end
			end
			default: r = 11'h000;
		endcase
		return r;
	endfunction

	// Builds a cycle count packet image as {length, bytes}; byte 0 is the header.
	function automatic logic [8*PB+2:0] f_cc_pkt(input logic [7:0] n, input logic [FW-1:0] inc);
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [2:0] len;
		logic [8*PB+2:0] r;
		b0 = 8'h00;
		b1 = 8'h00;
		b2 = 8'h00;
		len = 3'h0;
		r = {(8*PB+3){1'b0}};
		if ((n <= 8'h04) && (inc < 20'h00004)) begin
			b0 = eccte_pkg::HDR_CC3 | {4'h0, n[1:0] - 2'h1, inc[1:0]};
			r = {3'h1, 32'h0000_0000, b0};
		end else if ((n <= 8'h10) && (inc < 20'h00010)) begin
			b1 = {n[3:0] - 4'h1, inc[3:0]};
			r = {3'h2, 24'h00_0000, b1, eccte_pkg::HDR_CC2};
		end else begin
			b0 = {|inc[19:7], inc[6:0]};
			b1 = {|inc[19:14], inc[13:7]};
			b2 = {2'h0, inc[19:14]};
			len = 3'h3 + {2'h0, |inc[19:7]} + {2'h0, |inc[19:14]};
			r = {len, b2, b1, b0, {1'b0, n[6:0]}, eccte_pkg::HDR_CC1};
		end
		return r;
	endfunction

	eccte_pkt_if #(.BYTES(PB)) pkt_bus ();

	eccte_pkg::eccte_state_type st_q;
	eccte_pkg::eccte_state_type st_d;
	logic idle;
	logic eret_take;
	logic commit_take;
	logic mcu_eret;

	// Exception path.
	logic [10:0] exc_code;
	logic [31:0] addr_fix;
	logic align_word;
	logic align_half;
	logic exc_valid_q;
	logic [9:0] exc_type_q;
	logic [31:0] exc_addr_q;
	logic exc_unk_q;
	logic exc_rej_q;

	// Tag and speculation depth.
	logic [TAG_W-1:0] tag_q;
	logic [TAG_W-1:0] tag_d;
	logic [TAG_W-1:0] tag_inc;
	logic [DEPTH_W-1:0] depth_q;
	logic [DEPTH_W-1:0] depth_d;
	logic [DEPTH_W-1:0] depth_a;
	logic [DEPTH_W-1:0] depth_b;
	logic commit_ok;
	logic implied;
	logic commit_evt;
	logic implied_q;

	// Cycle counting.
	logic cc_on;
	logic cc_hit;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] inc;
	logic [6:0] pend_q;
	logic [6:0] pend_d;
	logic [7:0] n_commits;
	logic [8*PB+2:0] cc_img;
	logic cc_pend_q;
	logic [8*PB-1:0] cc_data_q;
	logic [2:0] cc_len_q;
	logic cc_emit_q;
	logic [CNT_W-1:0] cc_count_q;

	assign idle = st_q == eccte_pkg::ST_IDLE;
	assign EVT_READY_OUT = idle;
	assign eret_take = ERET_IN && idle;
	assign commit_take = COMMIT_IN && idle;
	// Only microcontroller cores touch tag and depth on a return.
	assign mcu_eret = eret_take && PROFILE_MCU_IN;

	assign exc_code = f_exc_code(EXC_KIND_IN, EXC_NUM_IN);
	assign align_word = EXC_ALIGN_IN && (EXC_ISET_IN == eccte_pkg::ISET_WORD);
	assign align_half = EXC_ALIGN_IN && (EXC_ISET_IN == eccte_pkg::ISET_COMPACT);
	assign addr_fix = align_word ? (EXC_ADDR_IN & eccte_pkg::ADDR_MASK_WORD) :
		(align_half ? (EXC_ADDR_IN & eccte_pkg::ADDR_MASK_HALF) : EXC_ADDR_IN);

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			exc_valid_q <= 1'b0;
			exc_type_q <= 10'h000;
			exc_addr_q <= 32'h0000_0000;
			exc_unk_q <= 1'b0;
			exc_rej_q <= 1'b0;
		end else begin
			// A reserved code is swallowed and only the reject pulse shows it.
			exc_valid_q <= EXC_VALID_IN && exc_code[10];
			exc_rej_q <= EXC_VALID_IN && !exc_code[10];
			exc_type_q <= exc_code[10] ? exc_code[9:0] : 10'h000;
			// The reset address still feeds the address history as usual.
			exc_addr_q <= addr_fix;
			exc_unk_q <= EXC_VALID_IN && (EXC_KIND_IN == eccte_pkg::KIND_RESET);
		end
	end

	assign EXC_VALID_OUT = exc_valid_q;
	assign EXC_TYPE_OUT = exc_type_q;
	assign EXC_ADDR_OUT = exc_addr_q;
	assign EXC_ADDR_UNKNOWN_OUT = exc_unk_q;
	assign EXC_REJECT_OUT = exc_rej_q;

	assign tag_inc = (tag_q == TAG_W'(TAG_WRAP - 1)) ? {TAG_W{1'b0}} : tag_q + 1'b1;
	assign tag_d = mcu_eret ? tag_inc : tag_q;
	// A core commit with nothing outstanding is ignored rather than wrapping the depth.
	assign commit_ok = commit_take && (depth_q != {DEPTH_W{1'b0}});
	assign depth_a = commit_ok ? depth_q - 1'b1 : depth_q;
	assign depth_b = mcu_eret ? depth_a + 1'b1 : depth_a;
	assign implied = depth_b > DEPTH_W'(MAX_DEPTH);
	assign depth_d = implied ? depth_b - 1'b1 : depth_b;
	assign commit_evt = commit_ok || implied;

	assign cc_on = CC_IMPL && CC_ENABLE_IN && CC_CONFIGURED_IN;
	assign cc_hit = cc_on && commit_evt && (cnt_q >= CC_THRESHOLD_IN);
	assign inc = cnt_q - CC_THRESHOLD_IN;
	// The cycle after a counted commit is already the first of the next interval, so it starts at one.
	assign cnt_d = !cc_on ? {CNT_W{1'b0}} : (cc_hit ? {{(CNT_W-1){1'b0}}, 1'b1} :
		((&cnt_q) ? cnt_q : cnt_q + 1'b1));
	// Commits below threshold are folded into the next packet; saturation caps the total.
	assign pend_d = (!cc_on || cc_hit) ? 7'h00 :
		((commit_evt && (pend_q != eccte_pkg::PEND_SAT)) ? pend_q + 7'h01 : pend_q);
	assign n_commits = {1'b0, pend_q} + 8'h01;
	assign cc_img = f_cc_pkt(n_commits, {{(FW-CNT_W){1'b0}}, inc});

	always_comb begin
		st_d = st_q;
		case (st_q)
			eccte_pkg::ST_IDLE: begin
				if (eret_take) begin
					st_d = eccte_pkg::ST_ERET;
				end else if (cc_hit) begin
					st_d = eccte_pkg::ST_CC;
				end
			end
			eccte_pkg::ST_ERET: begin
				if (pkt_bus.ready) begin
					st_d = cc_pend_q ? eccte_pkg::ST_CC : eccte_pkg::ST_IDLE;
				end
			end
			eccte_pkg::ST_CC: begin
				if (pkt_bus.ready) begin
					st_d = eccte_pkg::ST_IDLE;
				end
			end
			default: st_d = eccte_pkg::ST_IDLE;
		endcase
	end

	assign pkt_bus.valid = !idle;
	assign pkt_bus.data = (st_q == eccte_pkg::ST_ERET) ?
		{{(8*PB-8){1'b0}}, eccte_pkg::HDR_ERET} : cc_data_q;
	assign pkt_bus.len = (st_q == eccte_pkg::ST_ERET) ? eccte_pkg::ERET_LEN : cc_len_q;

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			st_q <= eccte_pkg::ST_IDLE;
			tag_q <= {TAG_W{1'b0}};
			depth_q <= {DEPTH_W{1'b0}};
			implied_q <= 1'b0;
			cnt_q <= {CNT_W{1'b0}};
			pend_q <= 7'h00;
		end else begin
			st_q <= st_d;
			tag_q <= tag_d;
			depth_q <= depth_d;
			implied_q <= implied;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			cc_pend_q <= 1'b0;
			cc_data_q <= {(8*PB){1'b0}};
			cc_len_q <= 3'h0;
			cc_emit_q <= 1'b0;
			cc_count_q <= {CNT_W{1'b0}};
		end else begin
			cc_emit_q <= cc_hit;
			if (cc_hit) begin
				cc_pend_q <= 1'b1;
				cc_data_q <= cc_img[8*PB-1:0];
				cc_len_q <= cc_img[8*PB+2:8*PB];
				cc_count_q <= cnt_q;
			end else if ((st_q == eccte_pkg::ST_CC) && pkt_bus.ready) begin
				cc_pend_q <= 1'b0;
			end
		end
	end

	assign TAG_OUT = tag_q;
	assign SPEC_DEPTH_OUT = depth_q;
	assign IMPLIED_COMMIT_OUT = implied_q;
	assign CC_EMIT_OUT = cc_emit_q;
	assign CC_COUNT_OUT = cc_count_q;

	eccte_byte_ser #(
		.BYTES(PB)
	) u_ser (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RESET_N_IN),
		.pkt(pkt_bus.snk),
		.byte_out(TRACE_DATA_OUT),
		.valid_out(TRACE_VALID_OUT),
		.ready_in(TRACE_READY_IN)
	);
endmodule
`default_nettype wire

// ---- logic/eccte_pkg.sv ----
// Purpose: Shared constants and types for the exception and cycle count trace encoder.
// Assumes: All users reach these names through the package scope.
// Notes: Byte 0 of a packet image sits in bits 7:0.
// Operation
// - Reset, NMI and the four fault kinds take codes 0x001 to 0x006.
// - Supervisor call 0x00b, monitor 0x00c, pended call 0x00e, tick 0x00f.
// - Interrupts 0-7 map from 0x010, interrupts 8-495 to 0x208-0x3ef.
// - Debug halt 0x018, lazy float push 0x019, lockup 0x01a.
// - Implementation codes 0x020-0x02f allowed; any other reserved code never leaves.
// - Alignment fault on word-aligned code clears return address bits 1:0.
// - Alignment fault on compact code clears return address bit 0.
// - Reset address is passed on normally but flagged as unknown.
// - Every exception return instruction yields an exception return packet.
// - That packet is the single header byte 0x07 with no payload.
// - Microcontroller return bumps tag and depth; overflow implies one commit.
// - Other profiles emit the return packet only, state untouched.
// - Cycle count packets need support, the enable bit and a configured control.
// - On each commit a packet goes out only when count reaches threshold.
// - Count spans cycles back to the last commit that carried a count.
// - A packet may carry commits; its count belongs to the last one.
// - Choose among large, medium and small formats; small always has commits.
`default_nettype none
package eccte_pkg;
	localparam logic [9:0] EXC_RESET = 10'h001;
	localparam logic [9:0] EXC_NMI = 10'h002;
	localparam logic [9:0] EXC_ESCALATED = 10'h003;
	localparam logic [9:0] EXC_MEM_MGMT = 10'h004;
	localparam logic [9:0] EXC_BUS_ERR = 10'h005;
	localparam logic [9:0] EXC_USAGE = 10'h006;
	localparam logic [9:0] EXC_SUPV_CALL = 10'h00b;
	localparam logic [9:0] EXC_DBG_MON = 10'h00c;
	localparam logic [9:0] EXC_PEND_CALL = 10'h00e;
	localparam logic [9:0] EXC_TICK = 10'h00f;
	localparam logic [9:0] EXC_IRQ_LOW = 10'h010;
	localparam logic [9:0] EXC_DBG_HALT = 10'h018;
	localparam logic [9:0] EXC_LAZY_FP = 10'h019;
	localparam logic [9:0] EXC_LOCKUP = 10'h01a;
	localparam logic [9:0] EXC_IMPDEF = 10'h020;
	localparam logic [9:0] EXC_IRQ_HIGH = 10'h200;
	localparam logic [8:0] IRQ_LOW_COUNT = 9'h008;
	localparam logic [8:0] IRQ_LAST = 9'h1ef;
	localparam logic [8:0] IMPDEF_COUNT = 9'h010;
	localparam logic [31:0] ADDR_MASK_WORD = 32'hffff_fffc;
	localparam logic [31:0] ADDR_MASK_HALF = 32'hffff_fffe;
	localparam logic [7:0] HDR_ERET = 8'h07;
	localparam logic [7:0] HDR_CC1 = 8'h0e;
	localparam logic [7:0] HDR_CC2 = 8'h0c;
	localparam logic [7:0] HDR_CC3 = 8'h10;
	localparam logic [2:0] ERET_LEN = 3'h1;
	localparam int PKT_BYTES = 5;
	localparam int CC_FIELD_W = 20;
	localparam logic [6:0] PEND_SAT = 7'h7e;
	typedef enum logic [3:0] {
		KIND_RESET = 4'h0, KIND_NMI = 4'h1, KIND_ESCALATED = 4'h2, KIND_MEM_MGMT = 4'h3,
		KIND_BUS_ERR = 4'h4, KIND_USAGE = 4'h5, KIND_SUPV_CALL = 4'h6, KIND_DBG_MON = 4'h7,
		KIND_PEND_CALL = 4'h8, KIND_TICK = 4'h9, KIND_IRQ = 4'ha, KIND_DBG_HALT = 4'hb,
		KIND_LAZY_FP = 4'hc, KIND_LOCKUP = 4'hd, KIND_IMPDEF = 4'he
	} eccte_kind_type;
	typedef enum logic [1:0] {
		ISET_WORD = 2'h0,
		ISET_COMPACT = 2'h1,
		ISET_OTHER = 2'h2
	} eccte_iset_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ERET = 3'h2,
		ST_CC = 3'h4
	} eccte_state_type;
endpackage
`default_nettype wire

// ---- logic/eccte_pkt_if.sv ----
// Purpose: Carries one whole packet image from the encoder to the byte serializer.
// Assumes: The image is stable while valid is high and ready is low.
// Notes: Length counts bytes from byte 0 upward.
`timescale 1ns/1ps
`default_nettype none
interface eccte_pkt_if #(
	parameter int BYTES = 5
);
	logic valid;
	logic ready;
	logic [8*BYTES-1:0] data;
	logic [2:0] len;
	modport src (output valid, output data, output len, input ready);
	modport snk (input valid, input data, input len, output ready);
endinterface
`default_nettype wire

// ---- logic/eccte_byte_ser.sv ----
// Purpose: Turns packet images into a byte stream with valid and ready.
// Assumes: Lengths never exceed the image width.
// Notes: A new image is taken as the last byte of the old one leaves, so packets run back to back.
`timescale 1ns/1ps
`default_nettype none
module eccte_byte_ser #(
	parameter int BYTES = 5
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	eccte_pkt_if.snk pkt,
	output logic [7:0] byte_out,
	output logic valid_out,
	input wire logic ready_in
);
	logic [8*BYTES-1:0] buf_q;
	logic [8*BYTES-1:0] buf_d;
	logic [2:0] rem_q;
	logic [2:0] rem_d;
	logic last;
	logic load;
	logic step;

	assign step = valid_out && ready_in;
	assign last = (rem_q == 3'h1) && ready_in;
	// Whole packets are loaded only when the buffer is empty or its last byte leaves, so bytes never mix.
	assign pkt.ready = (rem_q == 3'h0) || last;
	assign load = pkt.valid && pkt.ready;
	assign buf_d = load ? pkt.data : (step ? (buf_q >> 8) : buf_q);
	assign rem_d = load ? pkt.len : (step ? rem_q - 3'h1 : rem_q);
	assign valid_out = rem_q != 3'h0;
	assign byte_out = buf_q[7:0];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_q <= {(8*BYTES){1'b0}};
			rem_q <= 3'h0;
		end else begin
			buf_q <= buf_d;
			rem_q <= rem_d;
		end
	end
endmodule
`default_nettype wire

// ---- sim/eccte_chk.sv ----
// Purpose: Concurrent checks on the encoder top ports.
// Assumes: One clock domain with an active low asynchronous reset.
// Notes: Bound to every instance of the encoder top.
`timescale 1ns/1ps
`default_nettype none
module eccte_chk #(
	parameter int TAG_W = 5,
	parameter int TAG_WRAP = 32,
	parameter int DEPTH_W = 6,
	parameter int MAX_DEPTH = 16,
	parameter bit CC_IMPL = 1'b1
) (
	input wire logic SYS_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic PROFILE_MCU_IN,
	input wire logic EXC_VALID_IN,
	input wire logic [3:0] EXC_KIND_IN,
	input wire logic EXC_VALID_OUT,
	input wire logic [9:0] EXC_TYPE_OUT,
	input wire logic EXC_ADDR_UNKNOWN_OUT,
	input wire logic ERET_IN,
	input wire logic COMMIT_IN,
	input wire logic EVT_READY_OUT,
	input wire logic [TAG_W-1:0] TAG_OUT,
	input wire logic [DEPTH_W-1:0] SPEC_DEPTH_OUT,
	input wire logic IMPLIED_COMMIT_OUT,
	input wire logic CC_ENABLE_IN,
	input wire logic CC_CONFIGURED_IN,
	input wire logic CC_EMIT_OUT,
	input wire logic [7:0] TRACE_DATA_OUT,
	input wire logic TRACE_VALID_OUT,
	input wire logic TRACE_READY_IN
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	a_eret_tag_step: assert property (ERET_IN && EVT_READY_OUT && PROFILE_MCU_IN
		|=> TAG_OUT == TAG_W'((int'($past(TAG_OUT)) + 1) % TAG_WRAP))
		else $error("tag did not advance after a return");
	a_other_prof_still: assert property (ERET_IN && EVT_READY_OUT && !PROFILE_MCU_IN
		&& !COMMIT_IN |=> $stable(TAG_OUT) && $stable(SPEC_DEPTH_OUT))
		else $error("return on other profile moved tag or depth");
	a_eret_byte_out: assert property (ERET_IN && EVT_READY_OUT
		|=> !EVT_READY_OUT ##1 TRACE_VALID_OUT && TRACE_DATA_OUT == 8'h07)
		else $error("return byte missing or wrong");
	a_stream_hold: assert property (TRACE_VALID_OUT && !TRACE_READY_IN
		|=> TRACE_VALID_OUT && $stable(TRACE_DATA_OUT))
		else $error("byte dropped or changed while stalled");
	a_reset_unknown: assert property (EXC_VALID_IN && EXC_KIND_IN == 4'h0
		|=> EXC_VALID_OUT && EXC_ADDR_UNKNOWN_OUT && EXC_TYPE_OUT == 10'h001)
		else $error("reset exception coded wrongly");
	a_no_reserved_code: assert property (EXC_VALID_OUT |-> EXC_TYPE_OUT inside
		{[10'h001:10'h006], [10'h00b:10'h00c], [10'h00e:10'h01a], [10'h020:10'h02f],
		[10'h208:10'h3ef]})
		else $error("reserved exception code emitted");
	a_depth_cap: assert property ($rose(IMPLIED_COMMIT_OUT)
		|-> SPEC_DEPTH_OUT == MAX_DEPTH && $past(SPEC_DEPTH_OUT) == MAX_DEPTH)
		else $error("implied commit without full depth");
	a_cc_gated: assert property (CC_EMIT_OUT
		|-> CC_IMPL && $past(CC_ENABLE_IN) && $past(CC_CONFIGURED_IN))
		else $error("cycle count emitted while disabled");
	a_cc_stream: assert property (CC_EMIT_OUT |-> !EVT_READY_OUT ##1 TRACE_VALID_OUT)
		else $error("cycle count packet not started");
endmodule
bind eccte_top eccte_chk #(.TAG_W(TAG_W), .TAG_WRAP(TAG_WRAP), .DEPTH_W(DEPTH_W),
	.MAX_DEPTH(MAX_DEPTH), .CC_IMPL(CC_IMPL)) i_chk (.SYS_CLK_IN(SYS_CLK_IN),
	.RESET_N_IN(RESET_N_IN), .PROFILE_MCU_IN(PROFILE_MCU_IN), .EXC_VALID_IN(EXC_VALID_IN),
	.EXC_KIND_IN(EXC_KIND_IN), .EXC_VALID_OUT(EXC_VALID_OUT), .EXC_TYPE_OUT(EXC_TYPE_OUT),
	.EXC_ADDR_UNKNOWN_OUT(EXC_ADDR_UNKNOWN_OUT), .ERET_IN(ERET_IN), .COMMIT_IN(COMMIT_IN),
	.EVT_READY_OUT(EVT_READY_OUT), .TAG_OUT(TAG_OUT), .SPEC_DEPTH_OUT(SPEC_DEPTH_OUT),
	.IMPLIED_COMMIT_OUT(IMPLIED_COMMIT_OUT), .CC_ENABLE_IN(CC_ENABLE_IN),
	.CC_CONFIGURED_IN(CC_CONFIGURED_IN), .CC_EMIT_OUT(CC_EMIT_OUT),
	.TRACE_DATA_OUT(TRACE_DATA_OUT), .TRACE_VALID_OUT(TRACE_VALID_OUT),
	.TRACE_READY_IN(TRACE_READY_IN));
`default_nettype wire

// ---- sim/eccte_sink.sv ----
// Purpose: Trace analyzer side that takes the byte stream.
// Assumes: Bytes move on an edge where valid and ready are both high.
// Notes: Stalls one cycle in four so the hold path is used whenever a byte is waiting in that cycle.
`timescale 1ns/1ps
`default_nettype none
module eccte_sink (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] byte_in,
	input wire logic valid_in,
	output logic ready_out
);
	logic [7:0] got[$];
	logic [1:0] phase_q;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_q <= 2'h0;
			ready_out <= 1'b0;
		end else begin
			phase_q <= phase_q + 2'h1;
			ready_out <= (phase_q != 2'h2);
			if (valid_in && ready_out) got.push_back(byte_in);
		end
	end
endmodule
`default_nettype wire

// ---- sim/eccte_top_test.sv ----
// Purpose: Self-checking bench for the exception and cycle count trace encoder.
// Assumes: Inputs change at rising edges; outputs are read one ns after.
// Notes: Depth limit is lowered to 8 so overflow is reached quickly.
`timescale 1ns/1ps
`default_nettype none
module eccte_top_test;
	localparam int MAXD = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic prof = 1'b1;
	logic exc_v = 1'b0;
	logic [3:0] kind = 4'h0;
	logic [8:0] num = 9'h000;
	logic align = 1'b0;
	logic [1:0] iset = 2'h0;
	logic [31:0] addr = 32'h0000_0000;
	logic eret = 1'b0;
	logic commit = 1'b0;
	logic cc_en = 1'b0;
	logic cc_cfg = 1'b0;
	logic [11:0] thrs = 12'h000;
	logic exc_v_o, exc_unk, exc_rej, evt_rdy, implied, cc_emit, tvalid, tready;
	logic [9:0] exc_type;
	logic [31:0] exc_addr;
	logic [4:0] tag;
	logic [5:0] depth;
	logic [11:0] cc_count;
	logic [7:0] tdata;
	int cyc = 0;
	int last = 0;
	int n_mismatch = 0;
	int checks_done = 0;
	eccte_top #(.MAX_DEPTH(MAXD)) i_dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
		.PROFILE_MCU_IN(prof), .EXC_VALID_IN(exc_v), .EXC_KIND_IN(kind), .EXC_NUM_IN(num),
		.EXC_ALIGN_IN(align), .EXC_ISET_IN(iset), .EXC_ADDR_IN(addr), .EXC_VALID_OUT(exc_v_o),
		.EXC_TYPE_OUT(exc_type), .EXC_ADDR_OUT(exc_addr), .EXC_ADDR_UNKNOWN_OUT(exc_unk),
		.EXC_REJECT_OUT(exc_rej), .ERET_IN(eret), .COMMIT_IN(commit), .EVT_READY_OUT(evt_rdy),
		.TAG_OUT(tag), .SPEC_DEPTH_OUT(depth), .IMPLIED_COMMIT_OUT(implied),
		.CC_ENABLE_IN(cc_en), .CC_CONFIGURED_IN(cc_cfg), .CC_THRESHOLD_IN(thrs),
		.CC_EMIT_OUT(cc_emit), .CC_COUNT_OUT(cc_count), .TRACE_DATA_OUT(tdata),
		.TRACE_VALID_OUT(tvalid), .TRACE_READY_IN(tready));
	eccte_sink i_sink (.clk_in(clk), .rst_n_in(rst_n), .byte_in(tdata), .valid_in(tvalid),
		.ready_out(tready));
	always #12.5 clk = ~clk;
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// The ceiling sits far above the few hundred cycles the scenarios need, so only a hang reaches it.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic wait_rdy();
		int i;
		i = 0;
		// The encoder frees up once the serializer holds the packet, so the stream must drain too.
		do begin
			@(posedge clk);
			#1;
			i++;
		end while ((evt_rdy !== 1'b1 || tvalid !== 1'b0) && i < 400);
		check({evt_rdy, tvalid}, 2'b10);
		@(posedge clk);
	endtask
	task automatic exc(input logic [3:0] k, input logic [8:0] n, input logic [1:0] st,
		input logic al, input logic [31:0] a, input logic [9:0] code, input logic [31:0] ea);
		@(posedge clk);
		exc_v <= 1'b1;
		kind <= k;
		num <= n;
		iset <= st;
		align <= al;
		addr <= a;
		@(posedge clk);
		exc_v <= 1'b0;
		#1;
		check(exc_v_o, code != 10'h000);
		check(exc_type, code);
		check(exc_rej, code == 10'h000);
		check(exc_addr, ea);
		check(exc_unk, k == 4'h0);
	endtask
	task automatic t_codes();
		logic [9:0] fixed[13] = '{10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h006,
			10'h00b, 10'h00c, 10'h00e, 10'h00f, 10'h018, 10'h019, 10'h01a};
		logic [3:0] ks[9] = '{4'ha, 4'ha, 4'ha, 4'ha, 4'ha, 4'he, 4'he, 4'he, 4'hf};
		logic [8:0] ns[9] = '{9'h000, 9'h007, 9'h008, 9'h1ef, 9'h1f0, 9'h000, 9'h00f, 9'h010,
			9'h000};
		logic [9:0] cs[9] = '{10'h010, 10'h017, 10'h208, 10'h3ef, 10'h000, 10'h020, 10'h02f,
			10'h000, 10'h000};
		for (int i = 0; i < 13; i++) exc(4'(i < 10 ? i : i + 1), 9'h000, 2'h2, 1'b0,
			32'h0000_1234, fixed[i], 32'h0000_1234);
		for (int i = 0; i < 9; i++) exc(ks[i], ns[i], 2'h2, 1'b0, 32'h0000_1234, cs[i],
			32'h0000_1234);
		exc(4'h5, 9'h000, 2'h0, 1'b1, 32'h1000_0003, 10'h006, 32'h1000_0000);
		exc(4'h5, 9'h000, 2'h1, 1'b1, 32'h1000_0003, 10'h006, 32'h1000_0002);
		exc(4'h5, 9'h000, 2'h0, 1'b0, 32'h1000_0003, 10'h006, 32'h1000_0003);
	endtask
	task automatic do_eret(input logic mcu, input int etag, input int edep, input logic eimp);
		i_sink.got.delete();
		@(posedge clk);
		prof <= mcu;
		eret <= 1'b1;
		@(posedge clk);
		eret <= 1'b0;
		#1;
		check(tag, etag);
		check(depth, edep);
		check(implied, eimp);
		wait_rdy();
		check(i_sink.got.size(), 1);
		check(i_sink.got[0], 8'h07);
	endtask
	// A zero commit count means the packet content is not predicted and is only drained.
	task automatic do_commit(input int d, input int thr, input logic emit, input int edep,
		input int n);
		int inc;
		logic [7:0] want[$];
		inc = d - thr;
		wait_rdy();
		i_sink.got.delete();
		thrs <= 12'(thr);
		while (cyc + 1 - last < d) @(posedge clk);
		commit <= 1'b1;
		@(posedge clk);
		commit <= 1'b0;
		if (emit) last = cyc;
		#1;
		check(cc_emit, emit);
		check(depth, edep);
		if (emit && n > 0) check(cc_count, d);
		wait_rdy();
		if (n == 0) return;
		if (!emit) want = {};
		else if (n <= 4 && inc < 4) want = '{8'(8'h10 | ((n - 1) << 2) | inc)};
		else if (n <= 16 && inc < 16) want = '{8'h0c, 8'(((n - 1) << 4) | inc)};
		else begin
			want = '{8'h0e, 8'(n)};
			do begin
				want.push_back(8'(inc % 128) | (inc > 127 ? 8'h80 : 8'h00));
				inc = inc / 128;
			end while (inc > 0);
		end
		check(i_sink.got.size(), want.size());
		foreach (want[i]) check(i_sink.got[i], want[i]);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_codes();
		for (int i = 1; i <= MAXD; i++) do_eret(1'b1, i, i, 1'b0);
		do_eret(1'b1, MAXD + 1, MAXD, 1'b1);
		do_eret(1'b0, MAXD + 1, MAXD, 1'b0);
		cc_cfg <= 1'b1;
		do_commit(0, 0, 1'b0, 7, 1);
		cc_en <= 1'b1;
		cc_cfg <= 1'b0;
		do_commit(0, 0, 1'b0, 6, 1);
		cc_cfg <= 1'b1;
		do_commit(0, 0, 1'b1, 5, 0);
		do_commit(12, 10, 1'b1, 4, 1);
		do_commit(12, 4, 1'b1, 3, 1);
		do_commit(12, 20, 1'b0, 2, 1);
		do_commit(25, 20, 1'b1, 1, 2);
		do_commit(300, 0, 1'b1, 0, 1);
		do_commit(12, 0, 1'b0, 0, 1);
		conclude();
	end
endmodule
`default_nettype wire
